// file: atoc_defines.svh
// Register offsets, field positions, reset values and codes for the timer
`ifndef ATOC_DEFINES_SVH
`define ATOC_DEFINES_SVH

`define ATOC_OFF_CR1     12'h000
`define ATOC_OFF_SLAVE_CTRL_REG    12'h008
`define ATOC_OFF_IRQEN   12'h00C
`define ATOC_OFF_STATUS  12'h010
`define ATOC_OFF_EVGEN   12'h014
`define ATOC_OFF_CHMODE  12'h018
`define ATOC_OFF_CHEN    12'h020
`define ATOC_OFF_CNT     12'h024
`define ATOC_OFF_RELOAD  12'h02C
`define ATOC_OFF_CMP0    12'h034
`define ATOC_OFF_BDT     12'h044
`define ATOC_OFF_PRE     12'h048

`define ATOC_CR1_RUN     0
`define ATOC_CR1_OPM     3
`define ATOC_ST_UPD      0
`define ATOC_ST_COM      5
`define ATOC_ST_TRG      6
`define ATOC_EG_UG       0
`define ATOC_EG_COM      5
`define ATOC_IE_COMDMA   13

`define ATOC_SMS_TRIG    3'b110
`define ATOC_TS_FIN2     3'b110
`define ATOC_SEL_DIRECT  2'b01
`define ATOC_OM_FROZEN   3'b000
`define ATOC_OM_FLO      3'b100
`define ATOC_OM_FHI      3'b101
`define ATOC_OM_PWM1     3'b110
`define ATOC_OM_PWM2     3'b111

`define ATOC_RELOAD_RST  16'hFFFF
`define ATOC_STMASK      32'h0000_0061

`endif

// file: atoc_pkg.sv
// Types shared by the timer output control block
package atoc_pkg;
	typedef struct packed {
		logic [11:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} atoc_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} atoc_apb_rsp_s;

	typedef struct packed {
		logic [2:0] mode;
		logic       main_en;
		logic       comp_en;
	} atoc_chcfg_s;

	typedef enum logic [1:0] {
		ATOC_IDLE,
		ATOC_RUN
	} atoc_run_e;
endpackage

// file: atoc_timer.sv
// Output stage, commutation and one-pulse control of an advanced timer
// What this block does
// - Three protection levels freeze dead-time; only the top level also freezes output modes
// - Protection field accepts first write only
// - High filtered trigger clears reference until update
// - Clearing only in compare and PWM modes
// - Mode and enables preloaded, applied on commutation
// - Commutation from software bit or trigger rise
// - Commutation sets flag, interrupt and DMA request
// - Single-shot stops counter when it next reaches reload
// - Single-shot clear means counter runs repetitively
// - Slave trigger mode starts counter on edge
// - Select code picks filtered input two
// - Delay equals compare, pulse equals reload minus compare
// - Mode two rises at compare, falls at reload
// - Trigger edge sets counter run bit
// - Fast enable forces reference on trigger
// - Fast enable only in PWM modes
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "atoc_defines.svh"
module atoc_timer #(
	parameter int NCH = 4,
	parameter int CW  = 16
) (
	// Clock and reset
	input  wire logic                   CLK_SYS,
	input  wire logic                   NRST,
	// APB slave
	input  wire atoc_pkg::atoc_apb_req_s APB_REQ,
	output      atoc_pkg::atoc_apb_rsp_s APB_RSP,
	// Trigger inputs
	input  wire logic                   FILTERED_EXT_TRIGGER,
	input  wire logic                   TIMER_INPUT_TWO,
	input  wire logic                   TRIGGER_INPUT_EXT,
	// Channel outputs
	output      logic [NCH-1:0]         CHAN_OUT,
	output      logic [NCH-1:0]         CHAN_OUT_COMP,
	output      logic [NCH-1:0]         CHAN_REFERENCE,
	// Events
	output      logic                   IRQ,
	output      logic                   PHASE_SWITCH_DMA_REQ
);
	import atoc_pkg::*;

	typedef struct packed {
		logic [1:0]            lock;
		logic                  lock_written;
		logic [7:0]            deadtime;
		logic                  single_shot_mode;
		atoc_run_e             run;
		logic [2:0]            slave_mode_field;
		logic [2:0]            trigger_select;
		logic [1:0]            chan2_select;
		logic                  chan2_polarity;
		logic [15:0]           irq_en;
		logic [6:0]            status;
		logic [CW-1:0]         counter_value;
		logic [CW-1:0]         reload_value;
		logic [NCH-1:0][CW-1:0] compare;
		atoc_chcfg_s [NCH-1:0] pre_cfg;
		atoc_chcfg_s [NCH-1:0] act_cfg;
		logic [NCH-1:0]        ref_clear_enable;
		logic [NCH-1:0]        fast_enable;
		logic [NCH-1:0]        fast_held;
		logic [NCH-1:0]        ref_cleared;
		logic [NCH-1:0]        chan_reference;
		logic                  preload_on;
		logic                  trig_prev;
		logic                  tin_prev;
		logic                  dma_pulse;
		logic [31:0]           prdata;
	} atoc_state_s;

	atoc_state_s st_ff;
	atoc_state_s nxt_st;

	logic        wr;
	logic        rd;
	logic [31:0] wd;
	logic [11:0] ad;
	logic        mapped;
	logic        fin2;
	logic        trig_edge;
	logic        com_evt;
	logic        upd_evt;
	logic        ug;
	logic        at_reload;
	logic [31:0] rdv;

	assign wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
	assign rd = APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite;
	assign wd = APB_REQ.pwdata;
	assign ad = APB_REQ.paddr;
	// Channel-2 input mapped directly, polarity flips the sense
	assign fin2 = (st_ff.chan2_select == `ATOC_SEL_DIRECT) &&
		(TIMER_INPUT_TWO ^ st_ff.chan2_polarity);

	always_comb begin
		case (ad)
		`ATOC_OFF_CR1, `ATOC_OFF_SLAVE_CTRL_REG, `ATOC_OFF_IRQEN, `ATOC_OFF_STATUS,
		`ATOC_OFF_EVGEN, `ATOC_OFF_CHMODE, `ATOC_OFF_CHEN, `ATOC_OFF_CNT,
		`ATOC_OFF_RELOAD, `ATOC_OFF_BDT, `ATOC_OFF_PRE:
			mapped = 1'b1;
		default:
			mapped = (ad >= `ATOC_OFF_CMP0) &&
				(ad < `ATOC_OFF_CMP0 + 12'(4 * NCH));
		endcase
	end

	always_comb begin
		rdv = 32'h0000_0000;
		case (ad)
		`ATOC_OFF_CR1: begin
			rdv[`ATOC_CR1_RUN] = (st_ff.run == ATOC_RUN);
			rdv[`ATOC_CR1_OPM] = st_ff.single_shot_mode;
		end
		`ATOC_OFF_SLAVE_CTRL_REG:
			rdv[6:0] = {st_ff.trigger_select, 1'b0, st_ff.slave_mode_field};
		`ATOC_OFF_IRQEN:   rdv[15:0] = st_ff.irq_en;
		`ATOC_OFF_STATUS:  rdv[6:0] = st_ff.status;
		`ATOC_OFF_CNT:     rdv[CW-1:0] = st_ff.counter_value;
		`ATOC_OFF_RELOAD:  rdv[CW-1:0] = st_ff.reload_value;
		`ATOC_OFF_BDT:     rdv[9:0] = {st_ff.lock, st_ff.deadtime};
		`ATOC_OFF_PRE:     rdv[0] = st_ff.preload_on;
		`ATOC_OFF_CHMODE: begin
			for (int i = 0; i < NCH; i++) begin
				rdv[8*i +: 8] = {st_ff.ref_clear_enable[i],
					st_ff.pre_cfg[i].mode, st_ff.fast_enable[i], 1'b0,
					(i == 1) ? st_ff.chan2_select : 2'b00};
			end
		end
		`ATOC_OFF_CHEN: begin
			for (int i = 0; i < NCH; i++) begin
				rdv[4*i +: 4] = {st_ff.pre_cfg[i].comp_en, 1'b0,
					(i == 1) ? st_ff.chan2_polarity : 1'b0,
					st_ff.pre_cfg[i].main_en};
			end
		end
		default: begin
			for (int i = 0; i < NCH; i++) begin
				if (ad == `ATOC_OFF_CMP0 + 12'(4 * i)) begin
					rdv[CW-1:0] = st_ff.compare[i];
				end
			end
		end
		endcase
	end

	always_comb begin
		logic [2:0] mode;
		logic       pwm_mode;
		logic       forced;
		logic       fast_go;
		logic       cmp_lvl;
		mode     = 3'h0;
		pwm_mode = 1'b0;
		forced   = 1'b0;
		fast_go  = 1'b0;
		cmp_lvl  = 1'b0;

		nxt_st = st_ff;
		nxt_st.dma_pulse = 1'b0;
		// Edge detectors idle low, matching the pins after reset
		nxt_st.trig_prev = TRIGGER_INPUT_EXT;
		nxt_st.tin_prev  = fin2;
		// Read data captured in setup so pready can stay high
		if (rd) begin
			nxt_st.prdata = rdv;
		end
		ug = wr && (ad == `ATOC_OFF_EVGEN) && wd[`ATOC_EG_UG];
		// Commutation by software bit or external trigger rising edge
		com_evt = (wr && (ad == `ATOC_OFF_EVGEN) && wd[`ATOC_EG_COM]) ||
			(TRIGGER_INPUT_EXT && !st_ff.trig_prev);
		trig_edge = (st_ff.slave_mode_field == `ATOC_SMS_TRIG) &&
			(st_ff.trigger_select == `ATOC_TS_FIN2) &&
			fin2 && !st_ff.tin_prev;
		at_reload = (st_ff.counter_value == st_ff.reload_value);
		upd_evt = ug || ((st_ff.run == ATOC_RUN) && at_reload);

		// Register writes
		if (wr) begin
			unique case (ad)
			`ATOC_OFF_CR1: begin
				nxt_st.single_shot_mode = wd[`ATOC_CR1_OPM];
				nxt_st.run = wd[`ATOC_CR1_RUN] ? ATOC_RUN : ATOC_IDLE;
			end
			`ATOC_OFF_SLAVE_CTRL_REG: begin
				nxt_st.slave_mode_field = wd[2:0];
				nxt_st.trigger_select = wd[6:4];
			end
			`ATOC_OFF_IRQEN:  nxt_st.irq_en = wd[15:0];
			`ATOC_OFF_STATUS: nxt_st.status = st_ff.status & ~wd[6:0];
			`ATOC_OFF_CNT:    nxt_st.counter_value = wd[CW-1:0];
			`ATOC_OFF_RELOAD: nxt_st.reload_value = wd[CW-1:0];
			`ATOC_OFF_PRE:    nxt_st.preload_on = wd[0];
			`ATOC_OFF_BDT: begin
				// Protection field only takes the first write after reset
				if (!st_ff.lock_written) begin
					nxt_st.lock = wd[9:8];
					nxt_st.lock_written = 1'b1;
				end
				// Dead-time frozen at any protection level
				if (st_ff.lock == 2'b00) begin
					nxt_st.deadtime = wd[7:0];
				end
			end
			`ATOC_OFF_CHMODE: begin
				for (int i = 0; i < NCH; i++) begin
					nxt_st.ref_clear_enable[i] = wd[8*i+7];
					nxt_st.fast_enable[i] = wd[8*i+2];
					// Output modes frozen at the top level
					if (st_ff.lock != 2'b11) begin
						nxt_st.pre_cfg[i].mode = wd[8*i+4 +: 3];
					end
					if (i == 1) begin
						nxt_st.chan2_select = wd[9:8];
					end
				end
			end
			`ATOC_OFF_CHEN: begin
				for (int i = 0; i < NCH; i++) begin
					nxt_st.pre_cfg[i].main_en = wd[4*i];
					nxt_st.pre_cfg[i].comp_en = wd[4*i+2];
					if (i == 1) begin
						nxt_st.chan2_polarity = wd[5];
					end
				end
			end
			default: begin
				for (int i = 0; i < NCH; i++) begin
					if (ad == `ATOC_OFF_CMP0 + 12'(4 * i)) begin
						nxt_st.compare[i] = wd[CW-1:0];
					end
				end
			end
			endcase
		end

		// Without preload, configuration applies at once
		if (!st_ff.preload_on) begin
			nxt_st.act_cfg = nxt_st.pre_cfg;
		end else if (com_evt) begin
			nxt_st.act_cfg = nxt_st.pre_cfg;
		end

		// Counter run control
		if (trig_edge) begin
			nxt_st.run = ATOC_RUN;
		end
		if (st_ff.run == ATOC_RUN) begin
			if (at_reload) begin
				nxt_st.counter_value = '0;
				if (st_ff.single_shot_mode) begin
					nxt_st.run = ATOC_IDLE;
				end // Repetitive otherwise
			end else begin
				nxt_st.counter_value = st_ff.counter_value + 1'b1;
			end
		end
		if (ug) begin
			nxt_st.counter_value = '0;
		end

		// Reference generation per channel
		for (int i = 0; i < NCH; i++) begin
			mode = st_ff.act_cfg[i].mode;
			pwm_mode = (mode == `ATOC_OM_PWM1) ||
				(mode == `ATOC_OM_PWM2);
			forced = (mode == `ATOC_OM_FLO) ||
				(mode == `ATOC_OM_FHI);
			fast_go = trig_edge && st_ff.fast_enable[i] && pwm_mode;

			unique case (mode)
			`ATOC_OM_FLO: cmp_lvl = 1'b0;
			`ATOC_OM_FHI: cmp_lvl = 1'b1;
			`ATOC_OM_PWM1:
				cmp_lvl = st_ff.counter_value < st_ff.compare[i];
			`ATOC_OM_PWM2:
				// Low again at reload: pulse is reload minus compare
				cmp_lvl = (st_ff.counter_value >= st_ff.compare[i]) &&
					!at_reload;
			default: begin
				cmp_lvl = st_ff.chan_reference[i];
				if (st_ff.counter_value == st_ff.compare[i]) begin
					unique case (mode)
					3'b001: cmp_lvl = 1'b1;
					3'b010: cmp_lvl = 1'b0;
					3'b011: cmp_lvl = !st_ff.chan_reference[i];
					default: cmp_lvl = st_ff.chan_reference[i];
					endcase
				end
			end
			endcase

			// A fast-started pulse keeps the match level until update
			if (st_ff.fast_held[i] && pwm_mode) begin
				cmp_lvl = (mode == `ATOC_OM_PWM2) && !at_reload;
			end

			// Counter idle in PWM holds the reference low
			if (pwm_mode && st_ff.run != ATOC_RUN) begin
				cmp_lvl = 1'b0;
			end

			// Fast path skips the comparator latency on the trigger
			if (fast_go) begin
				cmp_lvl = (mode == `ATOC_OM_PWM2);
			end
			if (upd_evt) begin
				nxt_st.fast_held[i] = 1'b0;
			end else if (fast_go) begin
				nxt_st.fast_held[i] = 1'b1;
			end

			// Clear latch is set only outside forced modes
			if (upd_evt) begin
				nxt_st.ref_cleared[i] = 1'b0;
			end else if (FILTERED_EXT_TRIGGER && st_ff.ref_clear_enable[i] &&
				!forced) begin
				nxt_st.ref_cleared[i] = 1'b1;
			end

			// A latch left from an earlier mode never masks forced levels
			nxt_st.chan_reference[i] = cmp_lvl &&
				!(nxt_st.ref_cleared[i] && !forced);
		end

		// Sticky flags; a new event wins over a software clear
		if (com_evt) begin
			nxt_st.status[`ATOC_ST_COM] = 1'b1;
			nxt_st.dma_pulse = st_ff.irq_en[`ATOC_IE_COMDMA];
		end
		if (upd_evt) begin
			nxt_st.status[`ATOC_ST_UPD] = 1'b1;
		end
		if (trig_edge) begin
			nxt_st.status[`ATOC_ST_TRG] = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			st_ff <= '0;
			st_ff.run <= ATOC_IDLE;
			st_ff.reload_value <= `ATOC_RELOAD_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign APB_RSP.prdata  = st_ff.prdata;
	// No wait states: every access ends after one access cycle
	assign APB_RSP.pready  = 1'b1;
	assign APB_RSP.pslverr = APB_REQ.psel && APB_REQ.penable && !mapped;

	// Interrupt enable bits share the status layout
	assign IRQ = |(st_ff.status & st_ff.irq_en[6:0] &
		7'(`ATOC_STMASK));
	assign PHASE_SWITCH_DMA_REQ = st_ff.dma_pulse;

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			CHAN_REFERENCE[i] = st_ff.chan_reference[i];
			CHAN_OUT[i] = st_ff.act_cfg[i].main_en &&
				st_ff.chan_reference[i];
			// Complement only when both sides are enabled
			CHAN_OUT_COMP[i] = st_ff.act_cfg[i].comp_en &&
				(st_ff.act_cfg[i].main_en ? !st_ff.chan_reference[i]
				: st_ff.chan_reference[i]);
		end
	end
endmodule

// file: atoc_timer_properties.sv
// Port-level checker for the timer output control block
`timescale 1ns/1ps
`include "atoc_defines.svh"
module atoc_timer_chk
	import atoc_pkg::*;
#(
	parameter int NCH = 4
) (
	// Clock and reset
	input wire logic                    CLK_SYS,
	input wire logic                    NRST,
	// Bus and triggers
	input wire atoc_pkg::atoc_apb_req_s APB_REQ,
	input wire atoc_pkg::atoc_apb_rsp_s APB_RSP,
	input wire logic                    FILTERED_EXT_TRIGGER,
	input wire logic                    TRIGGER_INPUT_EXT,
	// Outputs
	input wire logic [NCH-1:0]          CHAN_OUT,
	input wire logic [NCH-1:0]          CHAN_REFERENCE,
	input wire logic                    PHASE_SWITCH_DMA_REQ
);
	logic [7:0] cfg0_ff;
	logic [2:0] since_ff;
	wire        wr_acc = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
	// Shadow of channel 0 config; lock-blocked writes still update it, so it can differ from the mode in use
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			cfg0_ff  <= 8'h00;
			since_ff <= 3'h7;
		end else begin
			if (wr_acc && APB_REQ.paddr == `ATOC_OFF_CHMODE)
				cfg0_ff <= APB_REQ.pwdata[7:0];
			if ((wr_acc && APB_REQ.paddr == `ATOC_OFF_EVGEN &&
				APB_REQ.pwdata[5]) || $rose(TRIGGER_INPUT_EXT))
				since_ff <= 3'h0;
			else if (since_ff != 3'h7)
				since_ff <= since_ff + 3'h1;
		end
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	a_ready_const: assert property (APB_RSP.pready)
		else $error("pready low");
	a_err_access: assert property (APB_RSP.pslverr |->
		APB_REQ.psel && APB_REQ.penable) else $error("pslverr outside access");
	a_rdata_hold: assert property (!(APB_REQ.psel && !APB_REQ.penable)
		|=> $stable(APB_RSP.prdata)) else $error("prdata moved");
	a_dma_single: assert property (
		PHASE_SWITCH_DMA_REQ |=> !PHASE_SWITCH_DMA_REQ)
		else $error("dma pulse too long");
	a_dma_cause: assert property (
		PHASE_SWITCH_DMA_REQ |-> since_ff < 3'h4)
		else $error("dma without commutation");
	a_out_gated: assert property (
		(CHAN_OUT & ~CHAN_REFERENCE) == '0) else $error("output without ref");
	a_ref_clear: assert property (
		FILTERED_EXT_TRIGGER && cfg0_ff[7] &&
		cfg0_ff[6:4] != `ATOC_OM_FHI && cfg0_ff[6:4] != `ATOC_OM_FLO
		|-> ##[1:2] !CHAN_REFERENCE[0]) else $error("ref not cleared");
	a_forced_keep: assert property (
		(cfg0_ff[6:4] == `ATOC_OM_FHI) [*3] |-> CHAN_REFERENCE[0])
		else $error("forced ref lost");
endmodule

bind atoc_timer atoc_timer_chk #(.NCH(NCH)) u_chk (.CLK_SYS, .NRST,
	.APB_REQ, .APB_RSP, .FILTERED_EXT_TRIGGER, .TRIGGER_INPUT_EXT,
	.CHAN_OUT, .CHAN_REFERENCE, .PHASE_SWITCH_DMA_REQ);

// file: atoc_drive_model.sv
// Trigger pins and current comparator facing the timer
`timescale 1ns/1ps
module atoc_drive_model (
	// Clock
	input  wire logic clk,
	// Stimulus toward the timer
	output      logic fet,
	output      logic ti2,
	output      logic trg
);
	initial begin
		fet = 1'b0;
		ti2 = 1'b0;
		trg = 1'b0;
	end
	// Width n lets a caller be prompt or slow; n must be at least 1
	task automatic edge_ti2(input int n);
		@(posedge clk) ti2 <= 1'b1;
		repeat (n) @(posedge clk);
		ti2 <= 1'b0;
	endtask
	task automatic edge_com(input int n);
		@(posedge clk) trg <= 1'b1;
		repeat (n) @(posedge clk);
		trg <= 1'b0;
	endtask
	task automatic set_fet(input logic v);
		@(posedge clk) fet <= v;
	endtask
endmodule

// file: tb.sv
// Self-checking bench for the timer output control block
`timescale 1ns/1ps
`include "atoc_defines.svh"
module tb;
	import atoc_pkg::*;
	logic          clk_sys;
	logic          nrst;
	atoc_apb_req_s req;
	atoc_apb_rsp_s rsp;
	logic          fet, ti2, trg, irq, dma, e;
	logic [3:0]    co, cc, rf;
	logic [31:0]   d;
	int            err_count, n_checks, t, k;
	int            dma_n = 0;
	atoc_timer dut (.CLK_SYS(clk_sys), .NRST(nrst), .APB_REQ(req),
		.APB_RSP(rsp), .FILTERED_EXT_TRIGGER(fet), .TIMER_INPUT_TWO(ti2),
		.TRIGGER_INPUT_EXT(trg), .CHAN_OUT(co), .CHAN_OUT_COMP(cc),
		.CHAN_REFERENCE(rf), .IRQ(irq), .PHASE_SWITCH_DMA_REQ(dma));
	atoc_drive_model pm (.clk(clk_sys), .fet(fet), .ti2(ti2), .trg(trg));
	always @(posedge clk_sys)
		if (dma === 1'b1)
			dma_n <= dma_n + 1;
	task automatic final_report();
		if (err_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, g);
		n_checks++;
		if (g !== x) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", nm, x, g);
		end
	endtask
	// One APB transfer; read data and error are left in d and e
	task automatic xfer(input logic [11:0] a, input logic w,
		input logic [31:0] v);
		@(posedge clk_sys) req <= '{a, 1'b1, 1'b0, w, v};
		@(posedge clk_sys) req.penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
		end while (rsp.pready !== 1'b1 && t < 16);
		d = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (t >= 16) begin
			chk("pready", 32'h0000_0001, 32'h0000_0000);
			final_report();
		end
	endtask
	task automatic wait_ref(input logic v);
		t = 0;
		do begin
			@(negedge clk_sys);
			t++;
		end while (rf[0] !== v && t < 200);
		if (t >= 200) begin
			chk("ref wait", 32'h0000_0001, 32'h0000_0000);
			final_report();
		end
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		nrst = 1'b0;
		req = '0;
		err_count = 0;
		n_checks = 0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		xfer(`ATOC_OFF_RELOAD, 1'b0, 32'h0000_0000);
		chk("reload rst", 32'h0000_FFFF, d);
		xfer(12'h004, 1'b0, 32'h0000_0000);
		chk("unmapped", 32'h0000_0001, {d[30:0], e});
		xfer(`ATOC_OFF_RELOAD, 1'b1, 32'h0000_0009);
		xfer(`ATOC_OFF_CMP0, 1'b1, 32'h0000_0004);
		xfer(`ATOC_OFF_CHMODE, 1'b1, 32'h0000_0170);
		xfer(`ATOC_OFF_CHEN, 1'b1, 32'h0000_0001);
		xfer(`ATOC_OFF_SLAVE_CTRL_REG, 1'b1, 32'h0000_0066);
		xfer(`ATOC_OFF_CR1, 1'b1, 32'h0000_0008);
		pm.edge_ti2(1);
		wait_ref(1'b1);
		chk("delay", 32'h0000_0001, 32'(t >= 3 && t <= 9));
		wait_ref(1'b0);
		chk("width", 32'h0000_0005, t);
		repeat (4) @(posedge clk_sys);
		xfer(`ATOC_OFF_CR1, 1'b0, 32'h0000_0000);
		chk("run clr", 32'h0000_0008, d);
		xfer(`ATOC_OFF_CNT, 1'b0, 32'h0000_0000);
		chk("cnt stop", 32'h0000_0000, d);
		xfer(`ATOC_OFF_CR1, 1'b1, 32'h0000_0001);
		repeat (30) @(posedge clk_sys);
		xfer(`ATOC_OFF_CR1, 1'b0, 32'h0000_0000);
		chk("repeat", 32'h0000_0001, d);
		xfer(`ATOC_OFF_CHMODE, 1'b1, 32'h0000_01F0);
		pm.set_fet(1'b1);
		repeat (3) @(negedge clk_sys);
		chk("clear", 32'h0000_0000, 32'(rf[0]));
		xfer(`ATOC_OFF_CHMODE, 1'b1, 32'h0000_01D0);
		repeat (3) @(negedge clk_sys);
		chk("forced", 32'h0000_0001, 32'(rf[0]));
		pm.set_fet(1'b0);
		xfer(`ATOC_OFF_CR1, 1'b1, 32'h0000_0000);
		xfer(`ATOC_OFF_CNT, 1'b1, 32'h0000_0000);
		xfer(`ATOC_OFF_RELOAD, 1'b1, 32'h0000_001E);
		xfer(`ATOC_OFF_CMP0, 1'b1, 32'h0000_0014);
		xfer(`ATOC_OFF_CHMODE, 1'b1, 32'h0000_0174);
		xfer(`ATOC_OFF_CR1, 1'b1, 32'h0000_0008);
		xfer(`ATOC_OFF_EVGEN, 1'b1, 32'h0000_0001);
		pm.edge_ti2(2);
		wait_ref(1'b1);
		chk("fast", 32'h0000_0001, 32'(t < 4));
		wait_ref(1'b0);
		xfer(`ATOC_OFF_CHMODE, 1'b1, 32'h0000_0150);
		xfer(`ATOC_OFF_IRQEN, 1'b1, 32'h0000_2020);
		xfer(`ATOC_OFF_PRE, 1'b1, 32'h0000_0001);
		xfer(`ATOC_OFF_CHEN, 1'b1, 32'h0000_0004);
		@(negedge clk_sys);
		chk("preload", 32'h0000_0001, {30'h0000_0000, cc[0], co[0]});
		k = dma_n;
		xfer(`ATOC_OFF_EVGEN, 1'b1, 32'h0000_0020);
		repeat (2) @(negedge clk_sys);
		chk("sw dma", k + 1, dma_n);
		chk("commute", 32'h0000_0002, {30'h0000_0000, cc[0], co[0]});
		chk("irq on", 32'h0000_0001, 32'(irq));
		xfer(`ATOC_OFF_STATUS, 1'b0, 32'h0000_0000);
		chk("flag", 32'h0000_0020, d & 32'h0000_0020);
		xfer(`ATOC_OFF_IRQEN, 1'b1, 32'h0000_2000);
		@(negedge clk_sys);
		chk("irq mask", 32'h0000_0000, 32'(irq));
		xfer(`ATOC_OFF_STATUS, 1'b1, 32'h0000_0020);
		xfer(`ATOC_OFF_STATUS, 1'b0, 32'h0000_0000);
		chk("flag clr", 32'h0000_0000, d & 32'h0000_0020);
		k = dma_n;
		pm.edge_com(2);
		repeat (3) @(negedge clk_sys);
		chk("hw dma", k + 1, dma_n);
		xfer(`ATOC_OFF_PRE, 1'b1, 32'h0000_0000);
		xfer(`ATOC_OFF_BDT, 1'b1, 32'h0000_0355);
		xfer(`ATOC_OFF_BDT, 1'b1, 32'h0000_01AA);
		xfer(`ATOC_OFF_BDT, 1'b0, 32'h0000_0000);
		chk("lock", 32'h0000_0355, d & 32'h0000_03FF);
		xfer(`ATOC_OFF_CHMODE, 1'b1, 32'h0000_0000);
		xfer(`ATOC_OFF_CHMODE, 1'b0, 32'h0000_0000);
		chk("frozen", 32'h0000_0050, d);
		final_report();
	end
endmodule
